// *** core/ascd_pkg.sv ***
// constants shared by the serial command decoder files
package ascd_pkg;

  // command byte decode positions
  localparam int unsigned CONV_SEL_BIT  = 7;
  localparam int unsigned SETUP_SEL_BIT = 6;
  localparam int unsigned AVG_SEL_BIT   = 5;
  localparam int unsigned RST_SEL_BIT   = 4;
  localparam int unsigned RST_SCOPE_BIT = 3;
  localparam int unsigned AVG_ON_BIT    = 4;

  // clock-mode codes
  localparam logic [1:0] TIMING_PIN_INT = 2'h0;
  localparam logic [1:0] TIMING_PIN_ACQ = 2'h1;
  localparam logic [1:0] TIMING_RESET   = 2'h2;
  localparam logic [1:0] TIMING_EXT_CLK = 2'h3;

  // reference codes
  localparam logic [1:0] VREF_INT_AUTO  = 2'h0;
  localparam logic [1:0] VREF_INT_ON    = 2'h2;
  localparam logic [1:0] VREF_EXT_DIFF  = 2'h3;

  // scan codes
  localparam logic [1:0] SCAN_REPEAT_N  = 2'h2;

  // counts and formats
  localparam logic [5:0]  AVG_BASE      = 6'h04;
  localparam logic [4:0]  REPEAT_STEP   = 5'h04;
  localparam logic [3:0]  LEAD_ZEROS    = 4'h0;
  localparam logic [11:0] SIGN_FLIP     = 12'h800;
  localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;

endpackage : ascd_pkg

// *** core/ascd_sync.sv ***
// two-flop synchroniser for a single level
`timescale 1ns/10ps
module ascd_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } ascd_sync_s;

  ascd_sync_s st_r;
  ascd_sync_s st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = d;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stage2;

endmodule : ascd_sync

// *** core/ascd_link.sv ***
// serial-clock side: byte framing in, result word shifted out
`timescale 1ns/10ps
module ascd_link (
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        din,
  input  wire logic [15:0] txWord,
  output logic             dout,
  output logic [7:0]       rxByte,
  output logic             rxToggle
);
  typedef struct packed {
    logic [6:0] shift;
    logic [7:0] rxByte;
    logic       rxToggle;
  } ascd_rx_s;

  ascd_rx_s   rx_r;
  ascd_rx_s   rx_nxt;
  logic [2:0] bitCnt_r;
  logic [3:0] txIdx_r;
  logic [3:0] txIdxNext;
  logic       dout_r;

  // framing restarts whenever chip select is high
  always_ff @(posedge sclk or posedge csN or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_r <= '0;
    end else if (csN) begin
      bitCnt_r <= '0;
    end else begin
      bitCnt_r <= bitCnt_r + 3'h1;
    end
  end

  always_comb begin
    rx_nxt       = rx_r;
    rx_nxt.shift = {rx_r.shift[5:0], din};
    if (bitCnt_r == ascd_pkg::LAST_BIT_IDX) begin
      rx_nxt.rxByte   = {rx_r.shift, din};
      rx_nxt.rxToggle = ~rx_r.rxToggle;
    end
  end

  // toggle is not reset by chip select so no event is invented or lost
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  // first bit of every word is a leading zero, so the async load is a constant
  assign txIdxNext = txIdx_r + 4'h1;

  always_ff @(negedge sclk or posedge csN or negedge rst_n) begin
    if (!rst_n) begin
      txIdx_r <= '0;
      dout_r  <= 1'b0;
    end else if (csN) begin
      txIdx_r <= '0;
      dout_r  <= 1'b0;
    end else begin
      txIdx_r <= txIdxNext;
      dout_r  <= txWord[4'hF - txIdxNext];
    end
  end

  assign dout     = dout_r;
  assign rxByte   = rx_r.rxByte;
  assign rxToggle = rx_r.rxToggle;

endmodule : ascd_link

// *** core/ascd_decoder.sv ***
// command decoder and configuration registers of the serial converter
// Function
// - Byte with bit 7 set writes conversion register; bits 6 and 0 ignored.
// - Conversion bits 5:3 pick the channel number N, inputs 0 to 7.
// - Scan 00: 0..N, 01: N..top, 10: repeat N, 11: N once.
// - Bit 7 clear, bit 6 set writes setup: clock, reference, pair target.
// - Clock modes: pin timed, pin acquisition, internal with pin as input 7, serial clock.
// - Reference: internal auto-off, external, internal always on, external differential.
// - Setup low field 10/11 routes the next byte to unipolar/bipolar pair register.
// - Setup low field 00/01 leaves pair registers; next byte is a command.
// - Pair enabled both unipolar and bipolar converts as unipolar.
// - Unipolar results straight binary, bipolar results two's complement.
// - Averaging enable bit 4 allows averaging in every scan mode, up to 32.
// - Clock mode 11 disables averaging regardless of enable bit.
// - Reset write: scope 1 clears result FIFO only, 0 restores all defaults.
// - Power-up: everything shut down, registers zero, clock mode 10.
// - Result word: four zero bits then 12-bit result, MSB first.
// - Data in sampled on rising serial clock, data out changes on falling.
// - Modes 00/01 start from convert pin; 10/11 start on conversion write.
// - Bits 7:5 = 001 writes averaging; count code selects 4, 8, 16, 32.
// - Repeat scan returns 4, 8, 12 or 16 results per count code.
// - Bits 7:4 = 0001 writes reset; bit 3 is scope, bits 2:0 ignored.
// - Pair register bits 7:4 enable pairs 0/1..6/7; bits 3:0 ignored.
`timescale 1ns/10ps
module ascd_decoder (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        din,
  output logic             dout,
  input  wire logic        convertStrobePin,
  input  wire logic        convDone,
  input  wire logic [11:0] convRaw,
  output logic             convStart,
  output logic             fifoClear,
  output logic [2:0]       channelPick,
  output logic [1:0]       scanMode,
  output logic [1:0]       timingSourceSel,
  output logic [1:0]       vrefSourceSel,
  output logic [3:0]       pairSinglePolarityEn,
  output logic [3:0]       pairSignedEn,
  output logic [3:0]       pairBipolarActive,
  output logic             averagingEnable,
  output logic [1:0]       averageCount,
  output logic [1:0]       repeatResultCount,
  output logic             averagingActive,
  output logic [5:0]       conversionsPerResult,
  output logic [4:0]       repeatResults,
  output logic             analogInputSeven,
  output logic             acquireByPin,
  output logic             sclkConversionClock,
  output logic             refAlwaysOn,
  output logic             refWakeDelay,
  output logic             refNegativePin
);
  typedef struct packed {
    logic        tglSeen;
    logic        pinPrev;
    logic        pending;
    logic        pendSigned;
    logic [2:0]  chan;
    logic [1:0]  scan;
    logic [1:0]  timing;
    logic [1:0]  vref;
    logic [3:0]  pairU;
    logic [3:0]  pairB;
    logic        avgEnable;
    logic [1:0]  avgCode;
    logic [1:0]  repeatCode;
    logic        startP;
    logic        fifoClrP;
    logic [15:0] resWord;
    logic        avgActive;
    logic [5:0]  convPerResult;
    logic [4:0]  repeatRes;
    logic [3:0]  pairBip;
    logic        pinIsIn7;
    logic        acqByPin;
    logic        sclkConv;
    logic        refOn;
    logic        refWake;
    logic        refNeg;
  } ascd_state_s;

  localparam ascd_state_s RESET_STATE = '{
    timing:        ascd_pkg::TIMING_RESET,
    convPerResult: ascd_pkg::AVG_BASE,
    repeatRes:     ascd_pkg::REPEAT_STEP,
    pinIsIn7:      1'b1,
    refWake:       1'b1,
    default:       '0
  };

  function automatic logic [4:0] ascd_repeat(input logic [1:0] code);
    ascd_repeat = 5'(({3'h0, code} + 5'h01) * ascd_pkg::REPEAT_STEP);
  endfunction : ascd_repeat

  function automatic logic [11:0] ascd_format(input logic [11:0] raw, input logic bipolar);
    ascd_format = bipolar ? (raw ^ ascd_pkg::SIGN_FLIP) : raw;
  endfunction : ascd_format

  ascd_state_s st_r;
  ascd_state_s st_nxt;
  logic        rstSync;
  logic        rxToggleSync;
  logic        pinSync;
  logic [7:0]  linkByte;
  logic        linkToggle;
  logic        newByte;
  logic        newCmd;
  logic        pinRise;
  logic        pairBipNow;

  ascd_sync u_rst_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rstSync)
  );

  ascd_sync u_tgl_sync (
    .clk   (clk),
    .rst_n (rstSync),
    .d     (linkToggle),
    .q     (rxToggleSync)
  );

  ascd_sync u_pin_sync (
    .clk   (clk),
    .rst_n (rstSync),
    .d     (convertStrobePin),
    .q     (pinSync)
  );

  // result word is held steady between conversions; the link reads it quasi-statically
  ascd_link u_link (
    .rst_n    (rstSync),
    .sclk     (sclk),
    .csN      (csN),
    .din      (din),
    .txWord   (st_r.resWord),
    .dout     (dout),
    .rxByte   (linkByte),
    .rxToggle (linkToggle)
  );

  // byte stays stable for a whole byte time, far longer than the toggle crossing
  assign newByte = rxToggleSync != st_r.tglSeen;
  assign newCmd  = newByte && !st_r.pending;
  assign pinRise = pinSync && !st_r.pinPrev;
  // format follows the pair of the current channel; channel change mid-scan is the caller's concern
  assign pairBipNow = st_r.pairBip[~st_r.chan[2:1]];

  always_comb begin
    st_nxt          = st_r;
    st_nxt.tglSeen  = rxToggleSync;
    st_nxt.pinPrev  = pinSync;
    st_nxt.startP   = 1'b0;
    st_nxt.fifoClrP = 1'b0;
    if (newByte && st_r.pending) begin
      st_nxt.pending = 1'b0;
      if (st_r.pendSigned) begin
        st_nxt.pairB = linkByte[7:4];
      end else begin
        st_nxt.pairU = linkByte[7:4];
      end
    end else if (newCmd && linkByte[ascd_pkg::CONV_SEL_BIT]) begin
      st_nxt.chan = linkByte[5:3];
      st_nxt.scan = linkByte[2:1];
      st_nxt.startP = st_r.timing[1];
    end else if (newCmd && linkByte[ascd_pkg::SETUP_SEL_BIT]) begin
      st_nxt.timing     = linkByte[5:4];
      st_nxt.vref       = linkByte[3:2];
      st_nxt.pending    = linkByte[1];
      st_nxt.pendSigned = linkByte[0];
    end else if (newCmd && linkByte[ascd_pkg::AVG_SEL_BIT]) begin
      st_nxt.avgEnable  = linkByte[ascd_pkg::AVG_ON_BIT];
      st_nxt.avgCode    = linkByte[3:2];
      st_nxt.repeatCode = linkByte[1:0];
    end else if (newCmd && linkByte[ascd_pkg::RST_SEL_BIT]) begin
      if (linkByte[ascd_pkg::RST_SCOPE_BIT]) begin
        st_nxt.fifoClrP = 1'b1;
      end else begin
        st_nxt         = RESET_STATE;
        st_nxt.tglSeen = rxToggleSync;
        st_nxt.pinPrev = pinSync;
      end
    end
    // pin starts only in the pin-driven clock modes
    if (pinRise && !st_r.timing[1]) begin
      st_nxt.startP = 1'b1;
    end
    if (convDone) begin
      st_nxt.resWord = {ascd_pkg::LEAD_ZEROS,
                        ascd_format(convRaw, pairBipNow)};
    end
    // derived flags are registered so every output leaves a flop
    st_nxt.avgActive     = st_nxt.avgEnable && (st_nxt.timing != ascd_pkg::TIMING_EXT_CLK);
    st_nxt.convPerResult = ascd_pkg::AVG_BASE << st_nxt.avgCode;
    st_nxt.repeatRes     = ascd_repeat(st_nxt.repeatCode);
    st_nxt.pairBip       = st_nxt.pairB & ~st_nxt.pairU;
    st_nxt.pinIsIn7      = st_nxt.timing[1];
    st_nxt.acqByPin      = (st_nxt.timing == ascd_pkg::TIMING_PIN_ACQ) && !pinSync;
    st_nxt.sclkConv      = st_nxt.timing == ascd_pkg::TIMING_EXT_CLK;
    st_nxt.refOn         = st_nxt.vref == ascd_pkg::VREF_INT_ON;
    st_nxt.refWake       = st_nxt.vref == ascd_pkg::VREF_INT_AUTO;
    st_nxt.refNeg        = st_nxt.vref == ascd_pkg::VREF_EXT_DIFF;
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign convStart            = st_r.startP;
  assign fifoClear            = st_r.fifoClrP;
  assign channelPick          = st_r.chan;
  assign scanMode             = st_r.scan;
  assign timingSourceSel      = st_r.timing;
  assign vrefSourceSel        = st_r.vref;
  assign pairSinglePolarityEn = st_r.pairU;
  assign pairSignedEn         = st_r.pairB;
  assign pairBipolarActive    = st_r.pairBip;
  assign averagingEnable      = st_r.avgEnable;
  assign averageCount         = st_r.avgCode;
  assign repeatResultCount    = st_r.repeatCode;
  assign averagingActive      = st_r.avgActive;
  assign conversionsPerResult = st_r.convPerResult;
  assign repeatResults        = st_r.repeatRes;
  assign analogInputSeven     = st_r.pinIsIn7;
  assign acquireByPin         = st_r.acqByPin;
  assign sclkConversionClock  = st_r.sclkConv;
  assign refAlwaysOn          = st_r.refOn;
  assign refWakeDelay         = st_r.refWake;
  assign refNegativePin       = st_r.refNeg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync);

  a_conv_chan_store: assert property (newCmd && linkByte[7] |=> channelPick == $past(linkByte[5:3]))
    else $error("channel not taken from conversion byte");
  a_conv_scan_store: assert property (newCmd && linkByte[7] |=> scanMode == $past(linkByte[2:1]))
    else $error("scan mode not taken from conversion byte");
  a_setup_fields: assert property (newCmd && linkByte[7:6] == 2'h1
                                   |=> timingSourceSel == $past(linkByte[5:4])
                                   && vrefSourceSel == $past(linkByte[3:2]))
    else $error("setup byte fields not stored");
  a_pair_unip_store: assert property (newByte && st_r.pending && !st_r.pendSigned
                                      |=> pairSinglePolarityEn == $past(linkByte[7:4])
                                      && pairSignedEn == $past(pairSignedEn))
    else $error("unipolar pair byte misrouted");
  a_pair_no_follow: assert property (newCmd && linkByte[7:6] == 2'h1 && !linkByte[1]
                                     |=> !st_r.pending && $stable(pairSinglePolarityEn)
                                     && $stable(pairSignedEn))
    else $error("pair registers touched by plain setup");
  a_unip_wins: assert property ((pairBipolarActive & pairSinglePolarityEn) == 4'h0)
    else $error("pair both unipolar and bipolar active");
  a_avg_ext_off: assert property (timingSourceSel == 2'h3 |-> !averagingActive)
    else $error("averaging active in serial clock mode");
  a_fifo_only: assert property (newCmd && linkByte[7:3] == 5'h03
                                |=> fifoClear && $stable(timingSourceSel) && $stable(channelPick))
    else $error("fifo clear changed registers");
  a_reset_all: assert property (newCmd && linkByte[7:3] == 5'h02
                                |=> timingSourceSel == 2'h2 && channelPick == 3'h0 && !fifoClear && !averagingEnable)
    else $error("register reset did not restore defaults");
  a_start_cause: assert property (convStart
                                  |-> ($past(newCmd) && $past(linkByte[7]) && $past(timingSourceSel[1]))
                                  || ($past(pinRise) && !$past(timingSourceSel[1])))
    else $error("conversion start without cause");
  // widened on purpose: code 11 gives 16, which a 3-bit product would lose
  a_repeat_count: assert property (repeatResults == ({3'h0, repeatResultCount} + 5'h01) * 5'h04)
    else $error("repeat result count wrong");
  a_lead_zeros: assert property (convDone |=> st_r.resWord[15:12] == 4'h0
                                 && st_r.resWord[11:0] == ($past(convRaw) ^ {$past(pairBipNow), 11'h000}))
    else $error("result word format wrong");
  a_pair_sign_store: assert property (newByte && st_r.pending && st_r.pendSigned
                                      |=> pairSignedEn == $past(linkByte[7:4])
                                      && $stable(pairSinglePolarityEn))
    else $error("bipolar pair byte misrouted");
  a_avg_fields: assert property (newCmd && linkByte[7:5] == 3'h1
                                 |=> averagingEnable == $past(linkByte[4])
                                 && averageCount == $past(linkByte[3:2]))
    else $error("averaging byte fields not stored");
  a_avg_active: assert property (averagingActive == (averagingEnable && timingSourceSel != 2'h3))
    else $error("averaging active flag wrong");
  a_per_result: assert property (conversionsPerResult == (6'h04 << averageCount))
    else $error("conversions per result wrong");
  a_clock_uses: assert property (analogInputSeven == timingSourceSel[1]
                                 && sclkConversionClock == (timingSourceSel == 2'h3))
    else $error("clock mode decode wrong");
  a_ref_uses: assert property (refAlwaysOn == (vrefSourceSel == 2'h2)
                               && refWakeDelay == (vrefSourceSel == 2'h0)
                               && refNegativePin == (vrefSourceSel == 2'h3))
    else $error("reference mode decode wrong");
  a_pin_start: assert property (pinRise && !timingSourceSel[1] |=> convStart)
    else $error("pin edge did not start a conversion");

  c_conv_write: cover property (newCmd && linkByte[7] ##1 convStart);
  c_pair_write: cover property (newByte && st_r.pending && st_r.pendSigned);
  c_fifo_clear: cover property (fifoClear);
  c_pin_start: cover property (pinRise && !timingSourceSel[1] ##1 convStart);
  c_avg_write: cover property (newCmd && linkByte[7:5] == 3'h1);

endmodule : ascd_decoder

// *** test/ascd_host_model.sv ***
// host serial master model: drives command frames and collects the reply word
`timescale 1ns/10ps
module ascd_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    din  = 1'b0;
  end

  // nb bits from d[15] down; serial clock only runs inside the frame
  task automatic xfer(input logic [15:0] d, input int nb, output logic [15:0] q);
    #1.3 csN = 1'b0;
    q = 16'h0000;
    for (int i = 0; i < nb; i++) begin
      din = d[15 - i];
      #3 sclk = 1'b1;
      q = {q[14:0], dout};
      #3 sclk = 1'b0;
    end
    #3 csN = 1'b1;
    // released line no longer shows the last bit
    din = ~din;
  endtask : xfer
endmodule : ascd_host_model

// *** test/tb.sv ***
// testbench: serial command sequences against the command decoder
`timescale 1ns/10ps
module tb;
  logic        clk, rst_n, sclk, csN, din, dout, convertStrobePin, convDone, convStart, fifoClear;
  logic [11:0] convRaw;
  logic [2:0]  channelPick;
  logic [1:0]  scanMode, timingSourceSel, vrefSourceSel, averageCount, repeatResultCount;
  logic [3:0]  pairSinglePolarityEn, pairSignedEn, pairBipolarActive;
  logic        averagingEnable, averagingActive, analogInputSeven, acquireByPin;
  logic        sclkConversionClock, refAlwaysOn, refWakeDelay, refNegativePin;
  logic [5:0]  conversionsPerResult;
  logic [4:0]  repeatResults;
  logic [15:0] rx;
  int          miscompares = 0;
  int          checked = 0;
  int          starts = 0;
  int          clears = 0;

  ascd_decoder i_dut (
    .clk, .rst_n, .sclk, .csN, .din, .dout, .convertStrobePin, .convDone, .convRaw, .convStart, .fifoClear,
    .channelPick, .scanMode, .timingSourceSel, .vrefSourceSel, .pairSinglePolarityEn, .pairSignedEn,
    .pairBipolarActive, .averagingEnable, .averageCount, .repeatResultCount, .averagingActive,
    .conversionsPerResult, .repeatResults, .analogInputSeven, .acquireByPin, .sclkConversionClock,
    .refAlwaysOn, .refWakeDelay, .refNegativePin
  );
  ascd_host_model i_host (.sclk, .csN, .din, .dout);

  always #2.5 clk = ~clk;

  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (convStart === 1'b1) starts++;
    if (fifoClear === 1'b1) clears++;
  end

  task automatic finish_test;
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // decode lands 2..3 clk after the last bit; 8 leaves margin
  task automatic send(input logic [15:0] d, input int nb);
    i_host.xfer(d, nb, rx);
    repeat (8) @(negedge clk);
  endtask : send

  task automatic rd(input logic [11:0] raw, input logic [15:0] exp);
    convRaw  = raw;
    convDone = 1'b1;
    @(negedge clk);
    convDone = 1'b0;
    repeat (4) @(negedge clk);
    i_host.xfer(16'h0000, 16, rx);
    chk(rx, exp, "result word");
    repeat (4) @(negedge clk);
  endtask : rd

  task automatic dflt;
    chk(timingSourceSel, 16'h0002, "clock mode");
    chk({analogInputSeven, refWakeDelay}, 16'h0003, "pin input, ref auto");
    chk({channelPick, scanMode, vrefSourceSel, averagingEnable, averageCount, repeatResultCount}, 16'h0000, "regs");
    chk({pairSinglePolarityEn, pairSignedEn}, 16'h0000, "pairs");
    chk(conversionsPerResult, 16'h0004, "avg count");
    chk(repeatResults, 16'h0004, "repeat count");
    chk(dout, 16'h0000, "dout idle");
  endtask : dflt

  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    int n;
    clk = 1'b0;
    rst_n = 1'b0;
    convertStrobePin = 1'b0;
    convDone = 1'b0;
    convRaw = 12'h000;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    dflt();
    // every channel and scan code, don't-care bits set
    for (int c = 0; c < 32; c++) begin
      n = starts;
      send({2'b11, c[4:0], 1'b1, 8'h00}, 8);
      chk(channelPick, c[4:2], "channel");
      chk(scanMode, c[1:0], "scan");
      chk(starts - n, 16'h0001, "byte start");
    end
    // all clock and reference codes, pin held low
    for (int c = 0; c < 16; c++) begin
      send({2'b01, c[3:0], 2'b00, 8'h00}, 8);
      chk(timingSourceSel, c[3:2], "clock code");
      chk(vrefSourceSel, c[1:0], "ref code");
      chk({analogInputSeven, sclkConversionClock, acquireByPin}, {c[3], c[3:2] == 3, c[3:2] == 1}, "ck use");
      chk({refWakeDelay, refAlwaysOn, refNegativePin}, {c[1:0] == 0, c[1:0] == 2, c[1:0] == 3}, "ref use");
    end
    send({8'h3C, 8'h00}, 8);
    chk({averagingEnable, averagingActive}, 16'h0002, "avg in ck 11");
    send({8'h60, 8'h00}, 8);
    for (int c = 0; c < 32; c++) begin
      send({3'b001, c[4:0], 8'h00}, 8);
      chk({averagingEnable, averageCount, repeatResultCount, averagingActive}, {c[4:0], c[4]}, "avg reg");
      if (c[4]) chk(conversionsPerResult, 16'h0004 << c[3:2], "avg n");
      chk(repeatResults, 16'h0004 * (c[1:0] + 16'h0001), "repeat n");
    end
    // setup plus pair byte in one 16-clock frame; low nibble ignored
    send({8'h62, 8'hA5}, 16);
    send({8'h63, 8'h6F}, 16);
    chk({pairSinglePolarityEn, pairSignedEn, pairBipolarActive}, 16'h0A64, "pairs");
    send({8'h61, 8'h8E}, 16);
    chk({pairSinglePolarityEn, pairSignedEn}, 16'h00A6, "pairs kept");
    chk(channelPick, 16'h0001, "second byte is command");
    send({8'h96, 8'h00}, 8);
    rd(12'h123, 16'h0923);
    send({8'hA6, 8'h00}, 8);
    rd(12'hABC, 16'h0ABC);
    n = clears;
    send({8'h1F, 8'h00}, 8);
    chk(clears - n, 16'h0001, "fifo clear");
    chk(channelPick, 16'h0004, "regs kept");
    send({8'h17, 8'h00}, 8);
    chk(clears - n, 16'h0001, "no clear on reset all");
    dflt();
    send({8'h40, 8'h00}, 8);
    n = starts;
    send({8'h86, 8'h00}, 8);
    chk(starts - n, 16'h0000, "no byte start in ck 00");
    convertStrobePin = 1'b1;
    repeat (8) @(negedge clk);
    chk(starts - n, 16'h0001, "pin start");
    // partial frame must not merge into the next byte
    send({4'hB, 12'h000}, 4);
    send({8'h50, 8'h00}, 8);
    chk({timingSourceSel, acquireByPin}, 16'h0002, "framing restart");
    convertStrobePin = 1'b0;
    repeat (8) @(negedge clk);
    chk(acquireByPin, 16'h0001, "pin acquisition");
    finish_test();
  end
endmodule : tb
